// ==== hw/tas_pkg.sv ====
`default_nettype none
package tas_pkg;
	// ==================================================
	// Register port geometry
	localparam int TAS_AW = 4; // Address width
	localparam int TAS_DW = 16; // Data width
	localparam int TAS_RW = 12; // Result width
	localparam int TAS_NCH = 5; // Channels in the mask
	// ==================================================
	// Register indices
	localparam logic [3:0] TAS_REG_RATE = 4'h0; // Automatic rate, 0 means manual
	localparam logic [3:0] TAS_REG_BIAS = 4'h1; // Bias settle delay, 0.5 us units
	localparam logic [3:0] TAS_REG_FSET = 4'h2; // Filter settle delay, 0.5 us units
	localparam logic [3:0] TAS_REG_OPT = 4'h3; // Filter order and aux trigger
	localparam logic [3:0] TAS_REG_MASK = 4'h4; // Channel mask
	localparam logic [3:0] TAS_REG_STAT = 4'h5; // Status, read clears touch flag
	localparam logic [3:0] TAS_REG_CMD = 4'h6; // Command word
	localparam logic [3:0] TAS_REG_RES0 = 4'h8; // First result, channel X
	localparam logic [3:0] TAS_REG_RES4 = 4'hc; // Last result, auxiliary
	// ==================================================
	// Field positions
	localparam int TAS_ST_CONV = 7; // Conversion done flag
	localparam int TAS_ST_TOUCH = 6; // Touch detect flag
	localparam int TAS_ST_BUSY = 5; // Sequencer busy
	localparam logic [3:0] TAS_OP_CONVERT = 4'h1; // Command opcodes in bits 7:4
	localparam logic [3:0] TAS_OP_SELECT = 4'h2;
	localparam logic [3:0] TAS_OP_MANUAL_AUTO_COMMAND = 4'h3;
	localparam logic [3:0] TAS_OP_PEN_DETECT_MODE = 4'h4;
	localparam logic [3:0] TAS_OP_PEN_TRIGGER_MODE = 4'h5;
	// ==================================================
	// Channel codes
	localparam logic [2:0] TAS_CH_X = 3'h0;
	localparam logic [2:0] TAS_CH_AUX = 3'h4;
	localparam logic [2:0] TAS_CH_SEQ = 3'h7; // Sequence all code
	// ==================================================
	// Timing
	localparam int TAS_CLK_NS = 100; // System clock period
	localparam int TAS_OSC_NS = 555; // Sequencing oscillator period
	localparam int TAS_OSC_CYC = (TAS_OSC_NS + TAS_CLK_NS - 1) / TAS_CLK_NS;
	localparam int TAS_UNIT_NS = 500; // Settle delay step, 0.5 us
	localparam int TAS_UNIT_CYC = (TAS_UNIT_NS + TAS_CLK_NS - 1) / TAS_CLK_NS;
	localparam int TAS_DLY_MAX_NS = 18190000; // Longest settle delay, 18.19 ms
	localparam logic [15:0] TAS_DLY_MAX = 16'(TAS_DLY_MAX_NS / TAS_UNIT_NS);
	localparam int TAS_WAKE_OSC = 47; // Overhead per conversion cycle
	localparam int TAS_CONV_OSC = 21; // One conversion
	localparam int TAS_TAIL_OSC = 1; // Per-channel wrap-up
	localparam int TAS_TMR_LAT = 2; // Load latency of the phase timer
	localparam int TAS_TW = 18; // Phase timer width
	// ==================================================
	// Types
	typedef enum logic [1:0] {TAS_M_MAN, TAS_M_PDET, TAS_M_PTRG} tas_mode_t;
	typedef enum {S_IDLE, S_ARM, S_WAKE, S_BIAS, S_CONV, S_FSET, S_TAIL, S_DONE} tas_state_t;
	typedef struct packed {
		logic [1:0] aux; // Aux trigger: 00 off, 01 rise, 10 fall, 11 both
		logic [1:0] filt; // Filter order: 1, 3, 5 or 7 conversions
	} tas_opt_t;
	typedef struct packed {
		logic [3:0] op;
		logic chan_sel_hi;
		logic [2:0] chan;
	} tas_cmd_t;
endpackage : tas_pkg
`default_nettype wire

// ==== hw/tas_timer.sv ====
`default_nettype none
// ==================================================
// Phase timer: counts a loaded value down, flags the last cycle
module tas_timer #(parameter int W = 18) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic load_in,
	input wire logic [W-1:0] value_in,
	output logic done_out
);
	logic [W-1:0] cnt; // Remaining cycles
	logic armed; // A phase is being timed

	// Load wins over a finishing count
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cnt <= '0;
			armed <= 1'b0;
		end else if (load_in) begin
			cnt <= value_in;
			armed <= 1'b1;
		end else if (armed && cnt == '0) begin
			armed <= 1'b0;
		end else if (cnt != '0) begin
			cnt <= cnt - W'(1);
		end
	end

	assign done_out = armed && cnt == '0;
endmodule : tas_timer
`default_nettype wire

// ==== hw/touch_acquisition_sequencer.sv ====
// What this block does
// - Starts in manual mode without configuration.
// - Single acquisition uses command channel field.
// - Sequence code walks mask MSB to LSB.
// - Mask one converts, zero skips channel.
// - Averaging repeats conversions with filter settle between.
// - Conversions per channel: one, three, five, seven.
// - Nonzero aux select starts on aux edges.
// - Aux edge runs bias settle before acquisition.
// - Interrupt low during power-up and reset.
// - Conversion end asserts interrupt, sets done flag.
// - Pen detect touch asserts interrupt, sets flag.
// - Done flag clears after all results read.
// - Status read clears touch flag, releases interrupt.
// - No conversion starts while interrupt asserted.
// - Cycle time: overhead, bias, settle, conversions.
// - Settle delays span 0.5 us to 18.19 ms.
// - Sequencing period 555 ns nominal.
// - Sequence holds one to five channels.
// - Rate zero manual, nonzero automatic.
// - Channel codes fixed, 101 and 110 reserved.
// - Channel biased before conversion, released after.
`default_nettype none
module touch_acquisition_sequencer import tas_pkg::*; #(
	parameter int POWERUP_CYCLES = 64, // Length of the power-up phase
	parameter int RATE_UNIT_CYCLES = 10000 // Cycles per automatic rate step
) (
	input wire logic SYS_CLK_IN,
	input wire logic RST_IN,
	input wire logic [TAS_AW-1:0] ADDR_IN,
	input wire logic [TAS_DW-1:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	input wire logic [TAS_RW-1:0] ADC_DATA_IN, // Converter result, same clock
	input wire logic TOUCH_IN, // Pen present, asynchronous pin
	input wire logic AUX_IN, // Auxiliary trigger, asynchronous pin
	output logic [TAS_DW-1:0] RDATA_OUT,
	output logic IRQ_N_OUT, // Interrupt level, low when asserted
	output logic IRQ_OE_OUT, // High while pulling the open-drain pin low
	output logic BIAS_EN_OUT, // Panel bias on
	output logic [2:0] BIAS_CHAN_OUT, // Biased channel
	output logic CONV_START_OUT // One-cycle converter start
);
	default clocking cb @(posedge SYS_CLK_IN); endclocking
	default disable iff (RST_IN);

	// ==================================================
	// Configuration and state
	logic [7:0] rate; // Automatic rate
	logic [15:0] bias_dly, fset_dly; // Settle delays in 0.5 us units
	tas_opt_t opt;
	logic [TAS_NCH-1:0] mask, mask_lat; // Channel mask, copy for a sequence
	tas_mode_t mode;
	tas_state_t state;
	logic [TAS_RW-1:0] result [TAS_NCH]; // Held results
	logic [TAS_NCH-1:0] unread; // Results not yet fetched
	logic conv_flag, touch_flag;
	logic [15:0] pwr_cnt; // Power-up countdown
	logic pwr_busy;
	logic [2:0] chan; // Channel being acquired
	logic seq; // Walking the mask
	logic [2:0] conv_cnt; // Conversions done on this channel
	logic sel_en; // Channel left biased by a select command
	logic [2:0] sel_chan;
	logic tmr_load;
	logic [TAS_TW-1:0] tmr_val;
	logic tmr_done;
	logic touch_s1, touch_s2, touch_d, aux_s1, aux_s2, aux_d;
	logic [13:0] unit_cnt; // Rate step prescaler
	logic [7:0] rate_cnt;
	logic auto_due; // Automatic interval elapsed

	tas_cmd_t cmd;
	logic cmd_wr, irq_req, aux_edge, touch_rise, start, seq_ok, nxt_found;
	logic [2:0] nfilt_m1, nxt_idx, first_idx;
	logic [3:0] first_pick; // Highest set bit of the live mask, with its found flag

	assign cmd = tas_cmd_t'(WDATA_IN[7:0]);
	assign cmd_wr = WR_IN && ADDR_IN == TAS_REG_CMD && !pwr_busy;
	assign irq_req = pwr_busy || conv_flag || touch_flag;
	assign nfilt_m1 = {opt.filt, 1'b0};
	assign touch_rise = touch_s2 && !touch_d;

	// ==================================================
	// Settle delay in cycles, clamped to the documented span
	function automatic logic [TAS_TW-1:0] dly_cyc(input logic [15:0] u);
		logic [15:0] c;
		c = (u == '0) ? 16'h0001 : (u > TAS_DLY_MAX) ? TAS_DLY_MAX : u;
		return TAS_TW'(c) * TAS_TW'(TAS_UNIT_CYC) - TAS_TW'(TAS_TMR_LAT);
	endfunction : dly_cyc

	function automatic logic [TAS_TW-1:0] osc_cyc(input int n);
		return TAS_TW'(n * TAS_OSC_CYC - TAS_TMR_LAT);
	endfunction : osc_cyc

	// Highest set mask bit below a limit
	function automatic logic [3:0] pick(input logic [TAS_NCH-1:0] m, input logic [2:0] lim);
		logic [3:0] r;
		r = '0;
		for (int i = 0; i < TAS_NCH; i++) begin
			if (m[i] && i < int'(lim)) begin
				r = {1'b1, 3'(i)};
			end
		end
		return r;
	endfunction : pick

	assign {nxt_found, nxt_idx} = pick(mask_lat, 3'(TAS_CH_AUX) - chan);
	assign first_pick = pick(mask, 3'(TAS_NCH));
	assign first_idx = first_pick[2:0];
	assign seq_ok = first_pick[3];

	// Edge qualification per aux select
	always_comb begin
		case (opt.aux)
			2'h1: aux_edge = aux_s2 && !aux_d;
			2'h2: aux_edge = !aux_s2 && aux_d;
			2'h3: aux_edge = aux_s2 != aux_d;
			default: aux_edge = 1'b0;
		endcase
	end

	// Start request, refused while the interrupt stands
	always_comb begin
		start = 1'b0;
		if (state == S_IDLE && !irq_req) begin
			case (mode)
				TAS_M_MAN: start = rate == '0 ? cmd_wr && cmd.op == TAS_OP_CONVERT &&
					(cmd.chan <= TAS_CH_AUX || (cmd.chan == TAS_CH_SEQ && seq_ok)) : auto_due && seq_ok;
				TAS_M_PTRG: start = touch_s2 && seq_ok;
				default: start = 1'b0;
			endcase
		end
	end

	// ==================================================
	// Pin synchronisers
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			{touch_s1, touch_s2, touch_d, aux_s1, aux_s2, aux_d} <= '0;
		end else begin
			touch_s1 <= TOUCH_IN;
			touch_s2 <= touch_s1;
			touch_d <= touch_s2;
			aux_s1 <= AUX_IN;
			aux_s2 <= aux_s1;
			aux_d <= aux_s2;
		end
	end

	// ==================================================
	// Configuration writes; reset leaves manual mode
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			rate <= '0;
			bias_dly <= '0;
			fset_dly <= '0;
			opt <= '0;
			mask <= '0;
			mode <= TAS_M_MAN;
			sel_en <= 1'b0;
			sel_chan <= TAS_CH_X;
		end else if (WR_IN && !pwr_busy) begin
			case (ADDR_IN)
				TAS_REG_RATE: rate <= WDATA_IN[7:0];
				TAS_REG_BIAS: bias_dly <= WDATA_IN;
				TAS_REG_FSET: fset_dly <= WDATA_IN;
				TAS_REG_OPT: opt <= tas_opt_t'(WDATA_IN[3:0]);
				TAS_REG_MASK: mask <= WDATA_IN[TAS_NCH-1:0];
				TAS_REG_CMD: begin
					case (cmd.op)
						TAS_OP_MANUAL_AUTO_COMMAND: mode <= TAS_M_MAN;
						TAS_OP_PEN_DETECT_MODE: mode <= TAS_M_PDET;
						TAS_OP_PEN_TRIGGER_MODE: mode <= TAS_M_PTRG;
						TAS_OP_SELECT: begin
							sel_en <= cmd.chan <= TAS_CH_AUX; // Reserved codes select nothing
							sel_chan <= cmd.chan;
						end
						TAS_OP_CONVERT: sel_en <= 1'b0;
						default: ;
					endcase
				end
				default: ;
			endcase
		end
	end

	// ==================================================
	// Automatic interval, counted only while idle
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN || state != S_IDLE || mode != TAS_M_MAN || rate == '0) begin
			unit_cnt <= '0;
			rate_cnt <= '0;
			auto_due <= 1'b0;
		end else if (unit_cnt == 14'(RATE_UNIT_CYCLES - 1)) begin
			unit_cnt <= '0;
			if (rate_cnt >= rate - 8'h01) begin
				auto_due <= 1'b1;
			end else begin
				rate_cnt <= rate_cnt + 8'h01;
			end
		end else begin
			unit_cnt <= unit_cnt + 14'h0001;
		end
	end

	// ==================================================
	// Acquisition sequencer
	always_ff @(posedge SYS_CLK_IN) begin
		tmr_load <= 1'b0;
		CONV_START_OUT <= 1'b0;
		if (RST_IN) begin
			state <= S_IDLE;
			chan <= TAS_CH_X;
			seq <= 1'b0;
			conv_cnt <= '0;
			mask_lat <= '0;
			tmr_val <= '0;
		end else begin
			case (state)
				S_IDLE: if (start) begin
					seq <= mode != TAS_M_MAN || rate != '0 || cmd.chan == TAS_CH_SEQ;
					chan <= (mode == TAS_M_MAN && rate == '0 && cmd.chan != TAS_CH_SEQ) ?
						cmd.chan : 3'(TAS_CH_AUX) - first_idx;
					mask_lat <= mask;
					tmr_load <= opt.aux == 2'h0;
					tmr_val <= osc_cyc(TAS_WAKE_OSC);
					state <= opt.aux != 2'h0 ? S_ARM : S_WAKE;
				end
				S_ARM: if (aux_edge) begin
					tmr_load <= 1'b1;
					tmr_val <= osc_cyc(TAS_WAKE_OSC);
					state <= S_WAKE;
				end
				S_WAKE: if (tmr_done) begin
					tmr_load <= 1'b1;
					tmr_val <= dly_cyc(bias_dly);
					state <= S_BIAS;
				end
				S_BIAS, S_FSET: if (tmr_done) begin
					tmr_load <= 1'b1;
					tmr_val <= osc_cyc(TAS_CONV_OSC);
					CONV_START_OUT <= 1'b1;
					state <= S_CONV;
				end
				S_CONV: if (tmr_done) begin
					tmr_load <= 1'b1;
					if (conv_cnt == nfilt_m1) begin
						conv_cnt <= '0;
						tmr_val <= osc_cyc(TAS_TAIL_OSC);
						state <= S_TAIL;
					end else begin
						conv_cnt <= conv_cnt + 3'h1;
						tmr_val <= dly_cyc(fset_dly);
						state <= S_FSET;
					end
				end
				S_TAIL: if (tmr_done) begin
					if (seq && nxt_found) begin
						chan <= 3'(TAS_CH_AUX) - nxt_idx;
						tmr_load <= 1'b1;
						tmr_val <= dly_cyc(bias_dly);
						state <= S_BIAS;
					end else begin
						state <= S_DONE;
					end
				end
				S_DONE: state <= S_IDLE;
				default: state <= S_IDLE;
			endcase
		end
	end

	tas_timer #(.W(TAS_TW)) u_timer (
		.clk_in(SYS_CLK_IN),
		.rst_in(RST_IN),
		.load_in(tmr_load),
		.value_in(tmr_val),
		.done_out(tmr_done)
	);

	// ==================================================
	// Result store; the last sample of a channel stands until the next cycle
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			for (int i = 0; i < TAS_NCH; i++) begin
				result[i] <= '0;
			end
		end else if (state == S_CONV && tmr_done) begin
			result[chan] <= ADC_DATA_IN;
		end
	end

	// Unread tracking; a new result wins over a read in the same cycle
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			unread <= '0;
		end else begin
			for (int i = 0; i < TAS_NCH; i++) begin
				if (state == S_CONV && tmr_done && int'(chan) == i) begin
					unread[i] <= 1'b1;
				end else if (RD_IN && ADDR_IN == TAS_REG_RES0 + 4'(i)) begin
					unread[i] <= 1'b0;
				end
			end
		end
	end

	// ==================================================
	// Power-up phase and interrupt flags
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			pwr_cnt <= 16'(POWERUP_CYCLES);
			pwr_busy <= 1'b1;
		end else if (pwr_cnt != '0) begin
			pwr_cnt <= pwr_cnt - 16'h0001;
		end else begin
			pwr_busy <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			conv_flag <= 1'b0;
			touch_flag <= 1'b0;
		end else begin
			if (state == S_DONE) begin
				conv_flag <= 1'b1;
			end else if (unread == '0) begin
				conv_flag <= 1'b0;
			end
			if (mode == TAS_M_PDET && touch_rise) begin
				touch_flag <= 1'b1;
			end else if (RD_IN && ADDR_IN == TAS_REG_STAT) begin
				touch_flag <= 1'b0;
			end
		end
	end

	// ==================================================
	// Pin drivers
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			IRQ_N_OUT <= 1'b0;
			IRQ_OE_OUT <= 1'b1;
			BIAS_EN_OUT <= 1'b0;
			BIAS_CHAN_OUT <= TAS_CH_X;
		end else begin
			IRQ_N_OUT <= !irq_req;
			IRQ_OE_OUT <= irq_req;
			// Bias drops in the wrap-up phase so the panel rests between channels
			BIAS_EN_OUT <= state inside {S_BIAS, S_CONV, S_FSET} || (state == S_IDLE && sel_en);
			BIAS_CHAN_OUT <= state == S_IDLE ? sel_chan : chan;
		end
	end

	// ==================================================
	// Register read port
	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN || !RD_IN) begin
			RDATA_OUT <= '0;
		end else begin
			case (ADDR_IN)
				TAS_REG_RATE: RDATA_OUT <= TAS_DW'(rate);
				TAS_REG_BIAS: RDATA_OUT <= bias_dly;
				TAS_REG_FSET: RDATA_OUT <= fset_dly;
				TAS_REG_OPT: RDATA_OUT <= TAS_DW'(opt);
				TAS_REG_MASK: RDATA_OUT <= TAS_DW'(mask);
				TAS_REG_STAT: RDATA_OUT <= TAS_DW'({conv_flag, touch_flag, state != S_IDLE, 3'h0, mode});
				default: RDATA_OUT <= (ADDR_IN >= TAS_REG_RES0 && ADDR_IN <= TAS_REG_RES4) ?
					TAS_DW'(result[3'(ADDR_IN - TAS_REG_RES0)]) : '0;
			endcase
		end
	end

	// ==================================================
	// Checks
	sequence s_done_seen;
		state == S_DONE;
	endsequence
	sequence s_irq_low;
		conv_flag ##1 !IRQ_N_OUT;
	endsequence

	chk_irq_in_reset: assert property (disable iff (1'b0) RST_IN |=> !IRQ_N_OUT && IRQ_OE_OUT)
		else $error("interrupt not held during reset");
	chk_irq_release: assert property (!irq_req |=> IRQ_N_OUT && !IRQ_OE_OUT)
		else $error("interrupt not released");
	chk_conv_irq_set: assert property (s_done_seen |=> s_irq_low)
		else $error("conversion end did not raise interrupt");
	chk_touch_irq: assert property (mode == TAS_M_PDET && touch_rise |=> touch_flag ##1 !IRQ_N_OUT)
		else $error("touch did not raise interrupt");
	chk_done_clear: assert property (conv_flag && unread == '0 && state != S_DONE |=> !conv_flag)
		else $error("done flag not cleared after reads");
	chk_status_clear: assert property (touch_flag && RD_IN && ADDR_IN == TAS_REG_STAT && !touch_rise |=> !touch_flag)
		else $error("status read did not clear touch flag");
	chk_no_start_irq: assert property (state == S_IDLE && irq_req |=> state == S_IDLE)
		else $error("conversion started under interrupt");
	chk_wake_length: assert property ($rose(state == S_WAKE) |-> (state == S_WAKE)[*8])
		else $error("overhead phase too short");
	chk_aux_to_bias: assert property (state == S_ARM && aux_edge |=> state == S_WAKE ##[1:300] state == S_BIAS)
		else $error("aux edge did not lead to bias settle");
	chk_filter_count: assert property (state == S_CONV && tmr_done && conv_cnt == nfilt_m1 |=> state == S_TAIL)
		else $error("wrong conversion count");
	chk_conv_pulse: assert property (CONV_START_OUT |-> state == S_CONV && $past(state) != S_CONV)
		else $error("start pulse outside conversion entry");
	chk_mask_honour: assert property (state == S_BIAS && seq |-> mask_lat[3'(TAS_CH_AUX) - chan])
		else $error("masked-off channel acquired");
	chk_result_hold: assert property (state != S_CONV |=> $stable(result[0]))
		else $error("result changed without conversion");
endmodule : touch_acquisition_sequencer
`default_nettype wire

// ==== verification/tas_panel_model.sv ====
`default_nettype none
// ==================================================
// Panel and converter stand-in, plus the interrupt pull-up
module tas_panel_model import tas_pkg::*; (
	input wire logic clk_in,
	input wire logic start_in,
	input wire logic [2:0] chan_in,
	input wire logic oe_in,
	output logic [TAS_RW-1:0] adc_out,
	output logic irq_pin_n_out
);
	timeunit 1ns;
	timeprecision 1ns;
	int left = 0; // Cycles left in the current conversion
	initial adc_out = 12'h000;
	// Open-drain line: pulled high unless the block sinks it
	assign irq_pin_n_out = oe_in ? 1'b0 : 1'b1;
	// Sample stands only inside a conversion; noise elsewhere exposes a late capture
	always @(posedge clk_in) begin
		if (start_in) begin
			left <= 130;
		end else if (left > 0) begin
			left <= left - 1;
		end
		if (start_in || left > 1) begin
			adc_out <= {1'b0, chan_in, 8'ha5}; // Never a low-high pressure pair
		end else begin
			adc_out <= ~adc_out;
		end
	end
endmodule : tas_panel_model
`default_nettype wire

// ==== verification/tb.sv ====
`default_nettype none
// ==================================================
// Self-checking bench of the acquisition sequencer
module tb import tas_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic [2:0] ch; logic [4:0] mask; logic [1:0] filt; logic [3:0] nst;} tas_row_t;
	// Channel, mask, filter order, expected converter starts
	localparam tas_row_t ROWS [8] = '{'{3'h0, 5'h00, 2'h0, 4'h1}, '{3'h1, 5'h00, 2'h1, 4'h3},
		'{3'h4, 5'h00, 2'h3, 4'h7}, '{3'h2, 5'h00, 2'h0, 4'h1}, '{3'h3, 5'h00, 2'h2, 4'h5},
		'{3'h7, 5'h1f, 2'h0, 4'h5}, '{3'h7, 5'h12, 2'h2, 4'ha}, '{3'h7, 5'h01, 2'h1, 4'h3}};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic touch = 1'b0;
	logic aux = 1'b0;
	logic aux_run = 1'b0; // Link clock runs only while a trigger is awaited
	logic [11:0] adc;
	logic [15:0] rdata;
	logic [2:0] bias_chan;
	logic irq_n, irq_oe, bias_en, conv_start, pin_n;
	int n_errors = 0;
	int tests_run = 0;
	int ns = 0; // Converter starts seen
	int nobias = 0; // Starts with the panel unbiased
	logic [23:0] hist = 24'h000000; // Last eight converted channels
	always #50 clk = ~clk;
	// Free link clock, toggling every 400 ns on falling edges of the system clock
	always begin
		#400;
		if (aux_run) aux = ~aux;
	end
	touch_acquisition_sequencer #(.POWERUP_CYCLES(4), .RATE_UNIT_CYCLES(20)) i_touch_acquisition_sequencer (
		.SYS_CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr_en), .RD_IN(rd_en),
		.ADC_DATA_IN(adc), .TOUCH_IN(touch), .AUX_IN(aux), .RDATA_OUT(rdata), .IRQ_N_OUT(irq_n),
		.IRQ_OE_OUT(irq_oe), .BIAS_EN_OUT(bias_en), .BIAS_CHAN_OUT(bias_chan), .CONV_START_OUT(conv_start));
	tas_panel_model i_tas_panel_model (.clk_in(clk), .start_in(conv_start), .chan_in(bias_chan),
		.oe_in(irq_oe), .adc_out(adc), .irq_pin_n_out(pin_n));
	// Record every converter start and the channel biased for it
	always @(posedge clk) begin
		if (conv_start === 1'b1) begin
			ns++;
			hist = {hist[20:0], bias_chan};
			if (bias_en !== 1'b1) nobias++;
		end
	end
	// ==================================================
	// Bus and compare tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 v = rdata;
	endtask : rd
	// Bounded wait for the interrupt line, counting edges
	task automatic wt(input logic v, output int c);
		c = 0;
		do begin
			@(posedge clk);
			#1 c++;
		end while (pin_n !== v && c < 4000);
		chk(pin_n, v);
		chk(irq_n, v);
	endtask : wt
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : give_verdict
	// Cuts a hang short
	initial begin
		#6000000;
		n_errors++;
		give_verdict();
	end
	// ==================================================
	// Main sequence
	initial begin
		int c, n, nch;
		logic [15:0] v;
		logic [23:0] eh;
		logic [4:0] cs;
		tas_row_t r;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1 chk(pin_n, 1'b0);
		wt(1'b1, c);
		rd(TAS_REG_STAT, v);
		chk(v, 16'h0000);
		wr(TAS_REG_BIAS, 16'h0002);
		wr(TAS_REG_FSET, 16'h0003);
		// Ordinary acquisitions, one row each
		foreach (ROWS[i]) begin
			r = ROWS[i];
			n = 2 * r.filt + 1;
			wr(TAS_REG_OPT, {14'h0000, r.filt});
			wr(TAS_REG_MASK, {11'h000, r.mask});
			ns = 0;
			hist = 24'h000000;
			wr(TAS_REG_CMD, {8'h00, TAS_OP_CONVERT, 1'b0, r.ch});
			wt(1'b0, c);
			eh = 24'h000000;
			cs = 5'h00;
			for (int b = 4; b >= 0; b--) begin
				if ((r.ch == 3'h7) ? r.mask[b] : (r.ch == 3'(4 - b))) begin
					cs[4 - b] = 1'b1;
					repeat (n) eh = {eh[20:0], 3'(4 - b)};
				end
			end
			nch = $countones(cs);
			chk(c, 284 + nch * (141 * n + 1));
			chk(ns, r.nst);
			chk(hist, eh);
			chk(bias_en, 1'b0);
			rd(TAS_REG_STAT, v);
			chk(v[7], 1'b1);
			// A start while the interrupt stands is ignored
			wr(TAS_REG_CMD, {8'h00, TAS_OP_CONVERT, 1'b0, r.ch});
			repeat (300) @(posedge clk);
			chk(ns, r.nst);
			for (int k = 0; k < 5; k++) begin
				if (cs[k]) begin
					chk(pin_n, 1'b0);
					rd(TAS_REG_RES0 + 4'(k), v);
					chk(v, {5'h00, 3'(k), 8'ha5});
				end
			end
			wt(1'b1, c);
			chk(c <= 3, 1'b1);
			rd(TAS_REG_STAT, v);
			chk(v[7], 1'b0);
		end
		// Reserved codes and an empty sequence start nothing
		wr(TAS_REG_MASK, 16'h0000);
		ns = 0;
		for (int k = 5; k < 8; k++) begin
			wr(TAS_REG_CMD, {8'h00, TAS_OP_CONVERT, 1'b0, 3'(k)});
			repeat (400) @(posedge clk);
			chk(ns, 0);
		end
		// Auxiliary edge triggers: rise, fall, both
		for (int a = 1; a < 4; a++) begin
			wr(TAS_REG_OPT, {12'h000, 2'(a), 2'h0});
			ns = 0;
			wr(TAS_REG_CMD, {8'h00, TAS_OP_CONVERT, 4'h0});
			repeat (300) @(posedge clk);
			chk(ns, 0);
			aux_run = 1'b1;
			wt(1'b0, c);
			aux_run = 1'b0;
			chk(ns, 1);
			rd(TAS_REG_RES0, v);
			wt(1'b1, c);
		end
		wr(TAS_REG_OPT, 16'h0000);
		// Touch detection raises the flag, a status read clears it
		wr(TAS_REG_CMD, {8'h00, TAS_OP_PEN_DETECT_MODE, 4'h0});
		@(posedge clk) touch <= 1'b1;
		wt(1'b0, c);
		chk(c < 12, 1'b1);
		rd(TAS_REG_STAT, v);
		chk(v[7:6], 2'b01);
		wt(1'b1, c);
		@(posedge clk) touch <= 1'b0;
		wr(TAS_REG_CMD, {8'h00, TAS_OP_MANUAL_AUTO_COMMAND, 4'h0});
		// Touch-triggered conversion
		wr(TAS_REG_MASK, 16'h0010);
		wr(TAS_REG_CMD, {8'h00, TAS_OP_PEN_TRIGGER_MODE, 4'h0});
		@(posedge clk) touch <= 1'b1;
		wt(1'b0, c);
		rd(TAS_REG_STAT, v);
		chk(v[7], 1'b1);
		@(posedge clk) touch <= 1'b0;
		wr(TAS_REG_CMD, {8'h00, TAS_OP_MANUAL_AUTO_COMMAND, 4'h0});
		rd(TAS_REG_RES0, v);
		wt(1'b1, c);
		// Nonzero rate converts on its own
		ns = 0;
		wr(TAS_REG_RATE, 16'h0001);
		wr(TAS_REG_CMD, {8'h00, TAS_OP_MANUAL_AUTO_COMMAND, 4'h0});
		wt(1'b0, c);
		chk(ns, 1);
		wr(TAS_REG_RATE, 16'h0000);
		rd(TAS_REG_RES0, v);
		wt(1'b1, c);
		// Select keeps a channel biased while idle; a reserved code biases nothing
		wr(TAS_REG_CMD, {8'h00, TAS_OP_SELECT, 4'h1});
		repeat (2) @(posedge clk);
		#1 chk({bias_en, bias_chan}, 4'h9);
		wr(TAS_REG_CMD, {8'h00, TAS_OP_SELECT, 4'h5});
		repeat (2) @(posedge clk);
		#1 chk(bias_en, 1'b0);
		// Reset in the middle of a conversion
		wr(TAS_REG_CMD, {8'h00, TAS_OP_CONVERT, 4'h0});
		repeat (300) @(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		@(posedge clk) rst <= 1'b0;
		#1 chk({pin_n, bias_en, rdata}, 18'h00000);
		wt(1'b1, c);
		chk(nobias, 0);
		give_verdict();
	end
endmodule : tb
`default_nettype wire
